// ---- rxcdr_map.svh ----
// Purpose: Offsets, field positions and counts of the receiver front end.
// Assumes: Included by bare name wherever a value is needed.
// Notes:   Definitions only.
`ifndef RXCDR_MAP_SVH
`define RXCDR_MAP_SVH

// ----------------------------------------
// Widths and depths
// ----------------------------------------
`define RXCDR_WORD_W    10
`define RXCDR_FIFO_D    8
`define RXCDR_PIN_W     5

// ----------------------------------------
// Positions of the synchronised pin fields
// ----------------------------------------
`define RXCDR_PIN_SER   0
`define RXCDR_PIN_PPM   2
`define RXCDR_PIN_LINE  4

// ----------------------------------------
// Counts
// ----------------------------------------
`define RXCDR_BEATS_W10 3'h5
`define RXCDR_BEATS_W8  3'h4
`define RXCDR_SD_ON     3'h6
`define RXCDR_SD_OFF    3'h2
`define RXCDR_SD_MAX    3'h7

`endif

// ---- rxcdr_pkg.sv ----
// Purpose: Types shared by the receiver front end.
// Assumes: Numbers live in rxcdr_map.svh.
// Notes:   Only types and small helpers here.
`include "rxcdr_map.svh"

package rxcdr_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {
		REF_TRACKING_STATE,
		DATA_TRACKING_STATE
	} rxcdr_lock_e;

	typedef logic [`RXCDR_WORD_W-1:0] rxcdr_word_t;

	// Beats of two bits that make one word.
	function automatic logic [2:0] rxcdrBeats(input logic wide);
		rxcdrBeats = wide ? `RXCDR_BEATS_W10 : `RXCDR_BEATS_W8;
	endfunction

endpackage

// ---- rxcdr_fifo.sv ----
// Purpose: Word buffer between the deserializer and the fabric.
// Assumes: D is a power of two.
// Notes:   Flip-flop storage; full and empty come from one count.
`timescale 1ns/1ps
`include "rxcdr_map.svh"

module rxcdr_fifo import rxcdr_pkg::*; #(
	parameter int W = `RXCDR_WORD_W,
	parameter int D = `RXCDR_FIFO_D
) (
	// Clock and reset.
	input  wire logic         clock,
	input  wire logic         rst_n,
	// Filling side.
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	// Draining side.
	output logic              outValid,
	input  wire logic         outReady,
	output logic [W-1:0]      outData
);
	localparam int PW = $clog2(D);
	localparam logic [PW:0] DEPTH_C = (PW+1)'(D);

	logic [W-1:0]  mem_r [D];
	logic [W-1:0]  mem_nxt [D];
	logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [PW:0]   cnt_r, cnt_nxt;
	logic          push, pop;

	// ----------------------------------------
	// Handshakes
	// ----------------------------------------
	assign inReady  = (cnt_r != DEPTH_C);
	assign outValid = (cnt_r != '0);
	assign outData  = mem_r[rd_r];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Pointers wrap by truncation, which is why D must be a power of two.
	always_comb begin
		mem_nxt = mem_r;
		wr_nxt  = wr_r;
		rd_nxt  = rd_r;
		if (push) begin
			mem_nxt[wr_r] = inData;
			wr_nxt        = PW'(wr_r + 1'b1);
		end
		if (pop) begin
			rd_nxt = PW'(rd_r + 1'b1);
		end
		cnt_nxt = (PW+1)'(cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
	end

	// Storage is not reset; only the bookkeeping is.
	always_ff @(posedge clock) begin
		mem_r <= mem_nxt;
		if (!rst_n) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_fifo_fill;
		@(posedge clock) disable iff (!rst_n)
		push && !pop |=> cnt_r == $past(cnt_r) + 1'b1;
	endproperty
	a_fifo_fill: assert property (p_fifo_fill) else $error("fifo count missed a push");

endmodule // rxcdr_fifo

// ---- rxcdr_sig_detect.sv ----
// Purpose: Line activity detector with hysteresis.
// Assumes: above is already synchronised to clock.
// Notes:   Short ringing moves the count but rarely both thresholds.
`timescale 1ns/1ps
`include "rxcdr_map.svh"

module rxcdr_sig_detect import rxcdr_pkg::*; (
	// Clock and reset.
	input  wire logic clock,
	input  wire logic rst_n,
	// Comparator level and filtered flag.
	input  wire logic above,
	output logic      detected
);
	logic [2:0] lvlCnt_r, lvlCnt_nxt;
	logic       det_r, det_nxt;

	assign detected = det_r;

	// ----------------------------------------
	// Hysteresis counter
	// ----------------------------------------
	// The flag sets high at one count and clears at a lower one.
	always_comb begin
		lvlCnt_nxt = lvlCnt_r;
		det_nxt    = det_r;
		if (above && lvlCnt_r != `RXCDR_SD_MAX) begin
			lvlCnt_nxt = lvlCnt_r + 3'h1;
		end else if (!above && lvlCnt_r != 3'h0) begin
			lvlCnt_nxt = lvlCnt_r - 3'h1;
		end
		if (lvlCnt_nxt >= `RXCDR_SD_ON) begin
			det_nxt = 1'b1;
		end else if (lvlCnt_nxt <= `RXCDR_SD_OFF) begin
			det_nxt = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lvlCnt_r <= 3'h0;
			det_r    <= 1'b0;
		end else begin
			lvlCnt_r <= lvlCnt_nxt;
			det_r    <= det_nxt;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_sd_fall;
		@(posedge clock) disable iff (!rst_n)
		$fell(det_r) |-> !$past(above) && $past(lvlCnt_r) == 3'h3;
	endproperty
	a_sd_fall: assert property (p_sd_fall) else $error("flag fell off threshold");

endmodule // rxcdr_sig_detect

// ---- rxcdr_lock_deser.sv ----
// Purpose: Clock recovery lock control and serial to parallel conversion.
// Assumes: Two serial bits per clock, the sample of each edge, bit 0 first.
// Notes:   Word output is buffered; a word meeting a full buffer is lost.
`timescale 1ns/1ps
`include "rxcdr_map.svh"
// Overview of operation
// - Start in reference tracking after reset.
// - Phase detector on only while tracking data.
// - Auto: go data when in tolerance; in PIPE mode also needs line activity.
// - Auto: return reference when tolerance lost.
// - Auto: lock flag follows data tracking.
// - Manual: fabric inputs choose tracking state.
// - Manual: lock flag high in data tracking.
// - Without manual inputs, run automatic mode.
// - Line activity flag uses hysteresis.
// - Without 8b/10b, activity flag held high.
// - Own unit; word strobe feeds receiver logic.
// - Reference from one of two PLLs.
// - Serial to 8 or 10 bits, LSB first.
// - Two bits per clock, both edges.
module rxcdr_lock_deser import rxcdr_pkg::*; (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Line side, not timed to clock.
	input  wire logic [1:0]  serBits,
	input  wire logic        lineAbove,
	input  wire logic [1:0]  ppmInTol,
	// Configuration from the fabric.
	input  wire logic        refPllSel,
	input  wire logic        pipeMode,
	input  wire logic        enc8b10b,
	input  wire logic        width10,
	input  wire logic        manualEn,
	input  wire logic        forceRef,
	input  wire logic        forceData,
	input  wire logic        ovfClear,
	// Status.
	output logic             phaseDetEn,
	output logic             trackData,
	output logic             freqLocked,
	output logic             lineActive,
	output logic             overflow,
	// Parallel words.
	output logic             outValid,
	input  wire logic        outReady,
	output rxcdr_word_t      outData
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [`RXCDR_PIN_W-1:0] pinSync1_r, pinSync1_nxt;
	logic [`RXCDR_PIN_W-1:0] pinSync2_r, pinSync2_nxt;
	logic [`RXCDR_PIN_W-1:0] pinSync3_r, pinSync3_nxt;
	logic [`RXCDR_PIN_W-1:0] pinStable_r, pinStable_nxt;
	logic [`RXCDR_PIN_W-1:0] pinDiff;
	logic [1:0]              beat;
	logic                    tolOk;
	logic                    lineRaw;
	logic                    sdFlag;
	logic                    lineAct_r, lineAct_nxt;
	rxcdr_lock_e             lockSt_r, lockSt_nxt;
	logic                    manualRef;
	logic                    manualData;
	logic                    autoUp;
	logic                    autoDown;
	logic [2:0]              beatCnt_r, beatCnt_nxt;
	rxcdr_word_t             shift_r, shift_nxt;
	logic                    pushValid_r, pushValid_nxt;
	rxcdr_word_t             pushData_r, pushData_nxt;
	logic                    pushReady;
	logic                    ovf_r, ovf_nxt;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Three stages; a bit moves on only when the second and third agree,
	// so a sample caught mid-transition never reaches the logic.
	always_comb begin
		pinSync1_nxt  = {lineAbove, ppmInTol, serBits};
		pinSync2_nxt  = pinSync1_r;
		pinSync3_nxt  = pinSync2_r;
		pinDiff       = pinSync2_r ^ pinSync3_r;
		pinStable_nxt = (pinSync2_r & ~pinDiff) | (pinStable_r & pinDiff);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinSync1_r  <= '0;
			pinSync2_r  <= '0;
			pinSync3_r  <= '0;
			pinStable_r <= '0;
		end else begin
			pinSync1_r  <= pinSync1_nxt;
			pinSync2_r  <= pinSync2_nxt;
			pinSync3_r  <= pinSync3_nxt;
			pinStable_r <= pinStable_nxt;
		end
	end

	// Field split of the settled pins.
	assign beat    = pinStable_r[`RXCDR_PIN_SER +: 2];
	assign lineRaw = pinStable_r[`RXCDR_PIN_LINE];

	// The tolerance verdict of the chosen neighbour PLL is used.
	assign tolOk = pinStable_r[`RXCDR_PIN_PPM + {31'h0, refPllSel}];

	// ----------------------------------------
	// Line activity
	// ----------------------------------------
	rxcdr_sig_detect u_sig_detect (
		.clock    (clock),
		.rst_n    (rst_n),
		.above    (lineRaw),
		.detected (sdFlag)
	);

	// Detection exists only on the coded path; elsewhere it reads active.
	always_comb begin
		lineAct_nxt = enc8b10b ? sdFlag : 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lineAct_r <= 1'b0;
		end else begin
			lineAct_r <= lineAct_nxt;
		end
	end

	assign lineActive = lineAct_r;

	// ----------------------------------------
	// Lock controller
	// ----------------------------------------
	// Manual inputs count only when they are enabled at all.
	assign manualRef  = manualEn && forceRef;
	assign manualData = manualEn && forceData && !forceRef;

	// Activity matters only in PIPE mode.
	assign autoUp   = tolOk && (!pipeMode || lineAct_r);
	assign autoDown = !tolOk || (pipeMode && !lineAct_r);

	// Manual levels override the detectors; both low hands control back.
	always_comb begin
		lockSt_nxt = lockSt_r;
		case (lockSt_r)
			REF_TRACKING_STATE: begin
				if (manualData || (!manualRef && autoUp)) begin
					lockSt_nxt = DATA_TRACKING_STATE;
				end
			end
			DATA_TRACKING_STATE: begin
				if (manualRef || (!manualData && autoDown)) begin
					lockSt_nxt = REF_TRACKING_STATE;
				end
			end
			default: begin
				lockSt_nxt = REF_TRACKING_STATE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lockSt_r <= REF_TRACKING_STATE;
		end else begin
			lockSt_r <= lockSt_nxt;
		end
	end

	// One lock flag serves both modes, so no mode can disagree with it.
	assign trackData  = (lockSt_r == DATA_TRACKING_STATE);
	assign phaseDetEn = trackData;
	assign freqLocked = trackData;

	// ----------------------------------------
	// Deserializer
	// ----------------------------------------
	// Bits shift in from the top so the first bit ends at bit 0. An 8-bit
	// word sits in the upper eight places and is moved down on output.
	// Outside data tracking the line is ignored and a partial word dropped.
	always_comb begin
		shift_nxt     = shift_r;
		beatCnt_nxt   = 3'h0;
		pushValid_nxt = 1'b0;
		pushData_nxt  = pushData_r;
		if (trackData) begin
			shift_nxt   = {beat[1], beat[0], shift_r[9:2]};
			beatCnt_nxt = beatCnt_r + 3'h1;
			if (beatCnt_nxt == rxcdrBeats(width10)) begin
				beatCnt_nxt   = 3'h0;
				pushValid_nxt = 1'b1;
				if (width10) begin
					pushData_nxt = shift_nxt;
				end else begin
					pushData_nxt = {2'h0, shift_nxt[9:2]};
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			shift_r     <= '0;
			beatCnt_r   <= 3'h0;
			pushValid_r <= 1'b0;
			pushData_r  <= '0;
		end else begin
			shift_r     <= shift_nxt;
			beatCnt_r   <= beatCnt_nxt;
			pushValid_r <= pushValid_nxt;
			pushData_r  <= pushData_nxt;
		end
	end

	// ----------------------------------------
	// Word buffer and overflow
	// ----------------------------------------
	// The line cannot be paused, so a stalled reader shows as overflow.
	rxcdr_fifo #(
		.W (`RXCDR_WORD_W),
		.D (`RXCDR_FIFO_D)
	) u_fifo (
		.clock    (clock),
		.rst_n    (rst_n),
		.inValid  (pushValid_r),
		.inReady  (pushReady),
		.inData   (pushData_r),
		.outValid (outValid),
		.outReady (outReady),
		.outData  (outData)
	);

	// A loss in the clearing cycle keeps the flag set.
	always_comb begin
		ovf_nxt = (pushValid_r && !pushReady) || (ovf_r && !ovfClear);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ovf_r <= 1'b0;
		end else begin
			ovf_r <= ovf_nxt;
		end
	end

	assign overflow = ovf_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_auto_up;
		!trackData && !manualRef && !manualData && autoUp;
	endsequence

	sequence s_auto_down;
		trackData && !manualRef && !manualData && autoDown;
	endsequence

	property p_reset_ref;
		$rose(rst_n) |-> !trackData && !freqLocked;
	endproperty
	a_reset_ref: assert property (p_reset_ref) else $error("not in reference after reset");

	property p_ignore_data;
		!trackData |=> beatCnt_r == 3'h0 && !pushValid_r;
	endproperty
	a_ignore_data: assert property (p_ignore_data) else $error("data taken in reference");

	property p_auto_up;
		s_auto_up |=> trackData && phaseDetEn;
	endproperty
	a_auto_up: assert property (p_auto_up) else $error("auto move to data missed");

	property p_pipe_hold;
		!trackData && !manualEn && pipeMode && !lineAct_r |=> !trackData;
	endproperty
	a_pipe_hold: assert property (p_pipe_hold) else $error("pipe moved without activity");

	property p_auto_down;
		s_auto_down |=> !trackData;
	endproperty
	a_auto_down: assert property (p_auto_down) else $error("auto return missed");

	property p_lock_flag;
		s_auto_up |=> $rose(freqLocked);
	endproperty
	a_lock_flag: assert property (p_lock_flag) else $error("lock flag off state");

	property p_force_ref;
		manualEn && forceRef |=> !trackData && !freqLocked;
	endproperty
	a_force_ref: assert property (p_force_ref) else $error("force reference ignored");

	property p_force_data;
		manualEn && forceData && !forceRef |=> trackData && freqLocked;
	endproperty
	a_force_data: assert property (p_force_data) else $error("force data ignored");

	property p_auto_only;
		((!manualEn && forceRef) and s_auto_up) |=> trackData;
	endproperty
	a_auto_only: assert property (p_auto_only) else $error("disabled manual input acted");

	property p_no_coding;
		!enc8b10b |=> lineActive;
	endproperty
	a_no_coding: assert property (p_no_coding) else $error("activity low without coding");

	property p_lsb_first10;
		pushValid_r && width10 && $past(trackData, 5) |-> pushData_r[1:0] == $past(beat, 5);
	endproperty
	a_lsb_first10: assert property (p_lsb_first10) else $error("10-bit word not LSB first");

	property p_lsb_first8;
		pushValid_r && !width10 && $past(trackData, 4) |->
			pushData_r[1:0] == $past(beat, 4) && pushData_r[9:8] == 2'h0;
	endproperty
	a_lsb_first8: assert property (p_lsb_first8) else $error("8-bit word not LSB first");

endmodule // rxcdr_lock_deser

// ---- rxcdr_tx_model.sv ----
// Purpose: Remote serial transmitter in front of the receiver front end.
// Assumes: Two line bits per clock, bit 0 earlier on the wire.
// Notes:   Repeats one bit pair inside a frame and inverts the line every clock outside.
`timescale 1ns/1ps

// ----------------------------------------
// Line driver
// ----------------------------------------
module rxcdr_tx_model import rxcdr_pkg::*; (
	// Clock.
	input  wire logic       clock,
	// Frame control from the bench.
	input  wire logic       sendEn,
	input  wire logic [1:0] pattern,
	// Line.
	output logic [1:0]      serBits
);
	// A repeated pair makes every word alike, so the boundary the receiver picks
	// cannot change what the bench expects; the idle line never rests on old bits.
	initial serBits = 2'h0;
	always @(posedge clock) begin
		if (sendEn) begin
			serBits <= pattern;
		end else begin
			serBits <= ~serBits;
		end
	end
endmodule // rxcdr_tx_model

// ---- rx_cdr_lock_and_deserializer_tb_top.sv ----
// Purpose: Self-checking bench of the lock controller and deserializer.
// Assumes: Design inputs move at the rising edge by non-blocking assignment.
// Notes:   Pins settle through synchronisers, so waits are bounded polls.
`timescale 1ns/1ps
`include "rxcdr_map.svh"

module rx_cdr_lock_and_deserializer_tb_top import rxcdr_pkg::*;;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clock, rst_n, lineAbove, refPllSel, pipeMode, enc8b10b, width10;
	logic        manualEn, forceRef, forceData, ovfClear, outReady, sendEn;
	logic [1:0]  serBits, ppmInTol, pattern;
	logic        phaseDetEn, trackData, freqLocked, lineActive, overflow, outValid;
	rxcdr_word_t outData, expW;
	logic [31:0] seed;
	int          n_errors, num_checks, n, sel, wide;

	rxcdr_lock_deser u_dut (.clock(clock), .rst_n(rst_n), .serBits(serBits),
		.lineAbove(lineAbove), .ppmInTol(ppmInTol), .refPllSel(refPllSel),
		.pipeMode(pipeMode), .enc8b10b(enc8b10b), .width10(width10),
		.manualEn(manualEn), .forceRef(forceRef), .forceData(forceData),
		.ovfClear(ovfClear), .phaseDetEn(phaseDetEn), .trackData(trackData),
		.freqLocked(freqLocked), .lineActive(lineActive), .overflow(overflow),
		.outValid(outValid), .outReady(outReady), .outData(outData));
	rxcdr_tx_model u_tx (.clock(clock), .sendEn(sendEn), .pattern(pattern),
		.serBits(serBits));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Free-running clock of 50 ns.
	initial clock = 1'b0;
	always #25 clock = ~clock;

	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// A repeated pair fills the word from bit 0 up; 8-bit words keep [9:8] zero.
	function automatic rxcdr_word_t expWord(input logic [1:0] p, input logic w10);
		rxcdr_word_t w;
		w = {5{p}};
		if (!w10) w[9:8] = 2'h0;
		return w;
	endfunction

	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Polls one status output (0 track, 1 activity, 2 valid) under a limit.
	task automatic waitFor(input int w, input logic want, input int lim, input string nm);
		int i;
		logic v;
		for (i = 0; i < lim; i++) begin
			v = (w == 0) ? trackData : (w == 1) ? lineActive : outValid;
			if (v === want) break;
			@(posedge clock);
			#1;
		end
		v = (w == 0) ? trackData : (w == 1) ? lineActive : outValid;
		chk(nm, {9'h0, want}, {9'h0, v});
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask

	task automatic end_of_test();
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	// The sequence needs about 400 cycles; far beyond that means a hang.
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_n, lineAbove, refPllSel, pipeMode, width10, manualEn} = 6'h0;
		{forceRef, forceData, ovfClear, outReady, sendEn} = 5'h0;
		{ppmInTol, pattern} = 4'h0;
		enc8b10b = 1'b1;
		seed = 32'h20;
		n_errors = 0;
		num_checks = 0;
		cyc(12);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		chk("trackData", 1'b0, trackData);
		chk("freqLocked", 1'b0, freqLocked);
		chk("outValid", 1'b0, outValid);
		// PIPE mode: tolerance alone must not lock; ringing must not raise activity.
		@(posedge clock);
		pipeMode <= 1'b1;
		ppmInTol <= 2'h3;
		for (n = 0; n < 30; n++) begin
			@(posedge clock);
			if (n[0]) lineAbove <= ~lineAbove;
			#1;
			chk("lineActive", 1'b0, lineActive);
		end
		chk("trackData", 1'b0, trackData);
		@(posedge clock);
		lineAbove <= 1'b1;
		waitFor(1, 1'b1, 20, "lineActive");
		waitFor(0, 1'b1, 6, "trackData");
		@(posedge clock);
		lineAbove <= 1'b0;
		waitFor(1, 1'b0, 20, "lineActive");
		waitFor(0, 1'b0, 6, "trackData");
		// Without the coding path the activity flag is forced high.
		@(posedge clock);
		{pipeMode, enc8b10b, ppmInTol} <= 4'h0;
		waitFor(1, 1'b1, 4, "lineActive");
		// Automatic mode with each reference choice; the other verdict is ignored.
		for (sel = 0; sel < 2; sel++) begin
			@(posedge clock);
			refPllSel <= sel[0];
			forceRef <= sel[0];
			ppmInTol <= sel[0] ? 2'h1 : 2'h2;
			cyc(20);
			#1;
			chk("trackData", 1'b0, trackData);
			@(posedge clock);
			ppmInTol <= 2'h3;
			waitFor(0, 1'b1, 20, "trackData");
			chk("freqLocked", 1'b1, freqLocked);
			chk("phaseDetEn", 1'b1, phaseDetEn);
			@(posedge clock);
			ppmInTol <= sel[0] ? 2'h1 : 2'h2;
			waitFor(0, 1'b0, 20, "trackData");
			chk("freqLocked", 1'b0, freqLocked);
			chk("phaseDetEn", 1'b0, phaseDetEn);
		end
		// Manual mode: force-data holds lock without tolerance, force-reference wins.
		@(posedge clock);
		{forceRef, ppmInTol, manualEn, forceData} <= 5'h03;
		waitFor(0, 1'b1, 6, "trackData");
		chk("freqLocked", 1'b1, freqLocked);
		@(posedge clock);
		forceRef <= 1'b1;
		waitFor(0, 1'b0, 6, "trackData");
		chk("freqLocked", 1'b0, freqLocked);
		@(posedge clock);
		{forceRef, forceData, ppmInTol} <= 4'h3;
		waitFor(0, 1'b1, 20, "trackData");
		@(posedge clock);
		ppmInTol <= 2'h0;
		waitFor(0, 1'b0, 20, "trackData");
		@(posedge clock);
		{manualEn, forceData} <= 2'h1;
		cyc(20);
		#1;
		chk("trackData", 1'b0, trackData);
		// Words of both widths; fill the buffer past full, then drain it.
		// Words caught during the lock tests are flushed before the word checks.
		@(posedge clock);
		forceData <= 1'b0;
		outReady <= 1'b1;
		cyc(12);
		outReady <= 1'b0;
		for (wide = 1; wide >= 0; wide--) begin
			seed = lfsrNext(seed);
			expW = expWord(seed[7:6], wide[0]);
			@(posedge clock);
			{width10, sendEn} <= {wide[0], 1'b1};
			pattern <= seed[7:6];
			cyc(8);
			ppmInTol <= 2'h3;
			waitFor(2, 1'b1, 30, "outValid");
			chk("outData", expW, outData);
			cyc(60);
			#1;
			chk("overflow", 1'b1, overflow);
			@(posedge clock);
			ppmInTol <= 2'h0;
			waitFor(0, 1'b0, 20, "trackData");
			@(posedge clock);
			{sendEn, ovfClear} <= 2'h1;
			@(posedge clock);
			{ovfClear, outReady} <= 2'h1;
			#1;
			chk("overflow", 1'b0, overflow);
			n = 0;
			repeat (12) begin
				if (outValid === 1'b1) begin
					n++;
					chk("outData", expW, outData);
				end
				@(posedge clock);
				#1;
			end
			chk("wordCount", 10'(`RXCDR_FIFO_D), 10'(n));
			chk("outValid", 1'b0, outValid);
			@(posedge clock);
			outReady <= 1'b0;
		end
		end_of_test();
	end
endmodule // rx_cdr_lock_and_deserializer_tb_top
